// *** include/occr_regs.svh ***
// register offsets, field positions, codes and reset values of the
// output channel configuration bank; included by the package and the rtl.
// Function
// - Hold channel five fraction bits 15:0
// - Channel six fraction top bits at 3:0
// - Channel six integer ratio is field plus one
// - Prescale codes: 000 two, 001 three, 111 one
// - Prescale bypassed while fraction divider is off
// - Bit 9 switches the fraction divider
// - Output control: off, clock, static low, high
// - Driver type: differential, single-ended, host differential
// - Bit 6 enables positive single-ended output
// - Negative side only works with positive side
// - Bit 8 selects slow single-ended edges
// - Bit 0 selects low or high supply
// - Supply bit cleared at power-up is tolerated
// - Channel seven control mirrors channel six layout
// - Channel seven divider word follows its control
`ifndef OCCR_REGS_SVH
`define OCCR_REGS_SVH

`define OCCR_ADDR_W          6
`define OCCR_DATA_W          16
`define OCCR_NUM_REGS        6
`define OCCR_IDX_W           3

`define OCCR_OFS_CH5_FRAC_LO 6'h0E
`define OCCR_OFS_CH6_CTRL    6'h0F
`define OCCR_OFS_CH6_DIV     6'h10
`define OCCR_OFS_CH6_FRAC_LO 6'h11
`define OCCR_OFS_CH7_CTRL    6'h12
`define OCCR_OFS_CH7_DIV     6'h13

`define OCCR_SUPPLY_BIT      0
`define OCCR_OUT_LSB         1
`define OCCR_OUT_MSB         2
`define OCCR_DRV_LSB         3
`define OCCR_DRV_MSB         4
`define OCCR_POS_BIT         6
`define OCCR_NEG_BIT         7
`define OCCR_SLOW_BIT        8
`define OCCR_FRAC_ON_BIT     9
`define OCCR_PRE_LSB         10
`define OCCR_PRE_MSB         12
`define OCCR_FRAC_HI_LSB     0
`define OCCR_FRAC_HI_MSB     3
`define OCCR_INT_LSB         4
`define OCCR_INT_MSB         11

`define OCCR_PRE_DIV2        3'h0
`define OCCR_PRE_DIV3        3'h1
`define OCCR_PRE_DIV1        3'h7

`define OCCR_RSVD_CTRL       16'hE020
`define OCCR_RSVD_DIV        16'hF000
`define OCCR_RSVD_FRAC       16'h0000
`define OCCR_RST_WORD        16'h0000

`endif

// *** include/occr_pkg.sv ***
// types shared by the configuration bank and its channel decoder.
// assumes occr_regs.svh sits on the include path.
`include "occr_regs.svh"

package occr_pkg;

   typedef enum logic [1:0] {
      OCCR_DRV_DIFF_LV,
      OCCR_DRV_SINGLE,
      OCCR_DRV_HOST_DIFF
   } occr_drv_t;

   // order matches the two-bit field codes 00..11
   typedef enum logic [1:0] {
      OCCR_OUT_OFF,
      OCCR_OUT_CLOCK,
      OCCR_OUT_LOW,
      OCCR_OUT_HIGH
   } occr_out_t;

   typedef struct packed {
      logic                    wr_en;
      logic                    rd_en;
      logic [`OCCR_ADDR_W-1:0] addr;
      logic [`OCCR_DATA_W-1:0] wdata;
   } occr_req_t;

   typedef struct packed {
      logic [8:0] int_ratio;
      logic [3:0] frac_hi;
      logic       frac_on;
      logic       prescale_bypass;
      logic [1:0] prescale_ratio;
      logic       prescale_bad;
      occr_drv_t  driver;
      logic       pos_on;
      logic       neg_on;
      logic       slow_edge;
      occr_out_t  out_ctl;
      logic       supply_high;
   } occr_chan_cfg_t;

endpackage : occr_pkg

// *** rtl/occr_chan_decode.sv ***
// decodes one channel's control and divider words into registered settings.
// assumes the words come from flops in the same clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "occr_regs.svh"

module occr_chan_decode (
   // clock and reset
   input  wire logic                     sys_clk,
   input  wire logic                     arst_n,
   // stored words
   input  wire logic [`OCCR_DATA_W-1:0]  ctrl_word,
   input  wire logic [`OCCR_DATA_W-1:0]  div_word,
   // decoded settings
   output var  occr_pkg::occr_chan_cfg_t cfg_r
);
   import occr_pkg::*;

   // what an all-zero pair of words decodes to
   localparam occr_chan_cfg_t CFG_RST = '{
      int_ratio: 9'h001, frac_hi: 4'h0, frac_on: 1'b0,
      prescale_bypass: 1'b1, prescale_ratio: 2'h1, prescale_bad: 1'b0,
      driver: OCCR_DRV_DIFF_LV, pos_on: 1'b0, neg_on: 1'b0,
      slow_edge: 1'b0, out_ctl: OCCR_OUT_OFF, supply_high: 1'b0};

   wire logic [2:0] pre_code;
   wire logic       frac_on;
   wire logic       pre_div2;
   wire logic       pre_div3;
   wire logic       pre_div1;
   wire logic [1:0] ratio;
   wire logic       pre_bad;
   wire occr_drv_t  drv;
   wire logic       pos_on;
   wire logic       neg_on;
   wire logic [8:0] int_ratio;
   occr_chan_cfg_t  cfg_nxt;

   assign pre_code  = ctrl_word[`OCCR_PRE_MSB:`OCCR_PRE_LSB];
   assign frac_on   = ctrl_word[`OCCR_FRAC_ON_BIT];
   assign pre_div2  = (pre_code == `OCCR_PRE_DIV2);
   assign pre_div3  = (pre_code == `OCCR_PRE_DIV3);
   assign pre_div1  = (pre_code == `OCCR_PRE_DIV1);
   // reserved codes fall back to divide by one and, with the fraction divider on, raise a flag
   assign ratio     = !frac_on ? 2'h1 : pre_div2 ? 2'h2 : pre_div3 ? 2'h3 : 2'h1;
   assign pre_bad   = frac_on & !(pre_div2 | pre_div3 | pre_div1);
   assign drv       = !ctrl_word[`OCCR_DRV_MSB] ? OCCR_DRV_DIFF_LV :
                      ctrl_word[`OCCR_DRV_LSB]  ? OCCR_DRV_HOST_DIFF : OCCR_DRV_SINGLE;
   assign pos_on    = ctrl_word[`OCCR_POS_BIT];
   // a lone negative enable is held off rather than trusted
   assign neg_on    = ctrl_word[`OCCR_NEG_BIT] & pos_on;
   assign int_ratio = {1'b0, div_word[`OCCR_INT_MSB:`OCCR_INT_LSB]} + 9'h001;

   assign cfg_nxt = '{
      int_ratio:       int_ratio,
      frac_hi:         div_word[`OCCR_FRAC_HI_MSB:`OCCR_FRAC_HI_LSB],
      frac_on:         frac_on,
      prescale_bypass: !frac_on,
      prescale_ratio:  ratio,
      prescale_bad:    pre_bad,
      driver:          drv,
      pos_on:          pos_on,
      neg_on:          neg_on,
      slow_edge:       ctrl_word[`OCCR_SLOW_BIT],
      out_ctl:         occr_out_t'(ctrl_word[`OCCR_OUT_MSB:`OCCR_OUT_LSB]),
      supply_high:     ctrl_word[`OCCR_SUPPLY_BIT]};

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_r <= CFG_RST;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

endmodule : occr_chan_decode

`default_nettype wire

// *** rtl/occr_top.sv ***
// output channel configuration bank: six 16-bit words behind a simple
// word-wide register port, decoded into per-channel settings.
// assumes the serial programming front end presents one-cycle read and
// write strobes synchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none
`include "occr_regs.svh"

module occr_top (
   // clock and reset
   input  wire logic                     sys_clk,
   input  wire logic                     arst_n,
   // register port
   input  wire occr_pkg::occr_req_t      req,
   output wire logic [`OCCR_DATA_W-1:0]  rd_data_r,
   output wire logic                     rd_valid_r,
   output wire logic                     addr_err_r,
   output wire logic                     rsvd_wr_r,
   // channel five
   output wire logic [`OCCR_DATA_W-1:0]  chan_five_fraction_low_r,
   // channel six
   output wire occr_pkg::occr_chan_cfg_t ch6_cfg_r,
   output wire logic [`OCCR_DATA_W-1:0]  chan_six_fraction_low_r,
   // channel seven
   output wire occr_pkg::occr_chan_cfg_t ch7_cfg_r
);
   import occr_pkg::*;

   localparam logic [`OCCR_IDX_W-1:0] IDX_CH5_FRAC =
      `OCCR_IDX_W'(`OCCR_OFS_CH5_FRAC_LO - `OCCR_OFS_CH5_FRAC_LO);
   localparam logic [`OCCR_IDX_W-1:0] IDX_CH6_CTRL =
      `OCCR_IDX_W'(`OCCR_OFS_CH6_CTRL - `OCCR_OFS_CH5_FRAC_LO);
   localparam logic [`OCCR_IDX_W-1:0] IDX_CH6_DIV =
      `OCCR_IDX_W'(`OCCR_OFS_CH6_DIV - `OCCR_OFS_CH5_FRAC_LO);
   localparam logic [`OCCR_IDX_W-1:0] IDX_CH6_FRAC =
      `OCCR_IDX_W'(`OCCR_OFS_CH6_FRAC_LO - `OCCR_OFS_CH5_FRAC_LO);
   localparam logic [`OCCR_IDX_W-1:0] IDX_CH7_CTRL =
      `OCCR_IDX_W'(`OCCR_OFS_CH7_CTRL - `OCCR_OFS_CH5_FRAC_LO);
   localparam logic [`OCCR_IDX_W-1:0] IDX_CH7_DIV =
      `OCCR_IDX_W'(`OCCR_OFS_CH7_DIV - `OCCR_OFS_CH5_FRAC_LO);

   logic [`OCCR_DATA_W-1:0] regs_r [`OCCR_NUM_REGS];
   logic [`OCCR_DATA_W-1:0] rd_data_q;
   logic                    rd_valid_q;
   logic                    addr_err_q;
   logic                    rsvd_wr_q;

   wire logic [`OCCR_ADDR_W-1:0] offset;
   wire logic [`OCCR_IDX_W-1:0]  idx;
   wire logic                    mapped;
   wire logic                    wr_ok;
   wire logic [`OCCR_DATA_W-1:0] rd_mux;
   wire logic [`OCCR_DATA_W-1:0] rsvd_mask;
   wire logic                    is_ctrl;
   wire logic                    is_div;
   wire logic [`OCCR_NUM_REGS-1:0] wr_hit;

   // address decode
   assign offset  = req.addr - `OCCR_OFS_CH5_FRAC_LO;
   assign mapped  = (req.addr >= `OCCR_OFS_CH5_FRAC_LO) &&
                    (req.addr <= `OCCR_OFS_CH7_DIV);
   assign idx     = offset[`OCCR_IDX_W-1:0];
   assign wr_ok   = req.wr_en & mapped;
   // unmapped reads answer zero so software sees a defined value
   assign rd_mux  = mapped ? regs_r[idx] : `OCCR_RST_WORD;
   assign is_ctrl = (idx == IDX_CH6_CTRL) || (idx == IDX_CH7_CTRL);
   assign is_div  = (idx == IDX_CH6_DIV) || (idx == IDX_CH7_DIV);
   assign rsvd_mask = is_ctrl ? `OCCR_RSVD_CTRL :
                      is_div  ? `OCCR_RSVD_DIV  : `OCCR_RSVD_FRAC;

   // word storage; reserved bits are kept so a read returns what was sent
   genvar gi;
   generate
      for (gi = 0; gi < `OCCR_NUM_REGS; gi++) begin : g_word
         assign wr_hit[gi] = wr_ok && (idx == `OCCR_IDX_W'(gi));
         always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
               regs_r[gi] <= `OCCR_RST_WORD;
            end else if (wr_hit[gi]) begin
               regs_r[gi] <= req.wdata;
            end
         end
      end
   endgenerate

   // read answers one cycle after the strobe; a write in the same cycle
   // is not visible until the next read
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data_q <= `OCCR_RST_WORD;
      end else if (req.rd_en) begin
         rd_data_q <= rd_mux;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_valid_q <= 1'b0;
         addr_err_q <= 1'b0;
         rsvd_wr_q  <= 1'b0;
      end else begin
         rd_valid_q <= req.rd_en;
         addr_err_q <= (req.rd_en | req.wr_en) & !mapped;
         // flags software that broke the zero-in-reserved convention
         rsvd_wr_q  <= wr_ok & |(req.wdata & rsvd_mask);
      end
   end

   assign rd_data_r  = rd_data_q;
   assign rd_valid_r = rd_valid_q;
   assign addr_err_r = addr_err_q;
   assign rsvd_wr_r  = rsvd_wr_q;

   assign chan_five_fraction_low_r = regs_r[IDX_CH5_FRAC];
   assign chan_six_fraction_low_r  = regs_r[IDX_CH6_FRAC];

   occr_chan_decode u_ch6 (
      .sys_clk   (sys_clk),
      .arst_n    (arst_n),
      .ctrl_word (regs_r[IDX_CH6_CTRL]),
      .div_word  (regs_r[IDX_CH6_DIV]),
      .cfg_r     (ch6_cfg_r)
   );

   // channel seven reuses the same decoder on its own words
   occr_chan_decode u_ch7 (
      .sys_clk   (sys_clk),
      .arst_n    (arst_n),
      .ctrl_word (regs_r[IDX_CH7_CTRL]),
      .div_word  (regs_r[IDX_CH7_DIV]),
      .cfg_r     (ch7_cfg_r)
   );

   // checking helpers
   logic past_ok_r;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         past_ok_r <= 1'b0;
      end else begin
         past_ok_r <= 1'b1;
      end
   end

   wire logic [`OCCR_DATA_W-1:0] ch6_ctrl_w;
   wire logic [`OCCR_DATA_W-1:0] ch6_div_w;
   wire logic [`OCCR_DATA_W-1:0] ch7_ctrl_w;
   wire logic [`OCCR_DATA_W-1:0] ch7_div_w;
   assign ch6_ctrl_w = regs_r[IDX_CH6_CTRL];
   assign ch6_div_w  = regs_r[IDX_CH6_DIV];
   assign ch7_ctrl_w = regs_r[IDX_CH7_CTRL];
   assign ch7_div_w  = regs_r[IDX_CH7_DIV];

   property p_read_back;
      @(posedge sys_clk) disable iff (!arst_n)
      (req.wr_en && mapped) ##1 (req.rd_en && !req.wr_en && req.addr == $past(req.addr))
      |=> rd_valid_r && rd_data_r == $past(req.wdata, 2);
   endproperty
   a_read_back: assert property (p_read_back) else $error("read does not return written word");

   property p_ch5_frac;
      @(posedge sys_clk) disable iff (!arst_n)
      (req.wr_en && req.addr == `OCCR_OFS_CH5_FRAC_LO)
      |=> chan_five_fraction_low_r == $past(req.wdata);
   endproperty
   a_ch5_frac: assert property (p_ch5_frac) else $error("channel five fraction not stored");

   property p_ch6_frac_hi;
      @(posedge sys_clk) disable iff (!arst_n)
      past_ok_r |-> ch6_cfg_r.frac_hi == $past(ch6_div_w[`OCCR_FRAC_HI_MSB:`OCCR_FRAC_HI_LSB]);
   endproperty
   a_ch6_frac_hi: assert property (p_ch6_frac_hi) else $error("channel six fraction top wrong");

   property p_ch6_int;
      @(posedge sys_clk) disable iff (!arst_n)
      past_ok_r |-> ch6_cfg_r.int_ratio ==
         {1'b0, $past(ch6_div_w[`OCCR_INT_MSB:`OCCR_INT_LSB])} + 9'h001;
   endproperty
   a_ch6_int: assert property (p_ch6_int) else $error("channel six integer ratio wrong");

   property p_prescale_code;
      @(posedge sys_clk) disable iff (!arst_n)
      (past_ok_r && ch6_cfg_r.frac_on) |->
         ch6_cfg_r.prescale_ratio == ($past(ch6_ctrl_w[`OCCR_PRE_MSB:`OCCR_PRE_LSB]) == `OCCR_PRE_DIV2 ? 2'h2 :
                                      $past(ch6_ctrl_w[`OCCR_PRE_MSB:`OCCR_PRE_LSB]) == `OCCR_PRE_DIV3 ? 2'h3 : 2'h1);
   endproperty
   a_prescale_code: assert property (p_prescale_code) else $error("prescale ratio decode wrong");

   property p_bypass;
      @(posedge sys_clk) disable iff (!arst_n)
      !ch7_cfg_r.frac_on |-> ch7_cfg_r.prescale_bypass && ch7_cfg_r.prescale_ratio == 2'h1
                             && !ch7_cfg_r.prescale_bad;
   endproperty
   a_bypass: assert property (p_bypass) else $error("prescale not bypassed");

   property p_frac_on;
      @(posedge sys_clk) disable iff (!arst_n)
      (req.wr_en && req.addr == `OCCR_OFS_CH6_CTRL) |-> ##2 ch6_cfg_r.frac_on == $past(req.wdata[`OCCR_FRAC_ON_BIT], 2);
   endproperty
   a_frac_on: assert property (p_frac_on) else $error("fraction enable not applied two cycles on");

   property p_out_ctl;
      @(posedge sys_clk) disable iff (!arst_n)
      past_ok_r |-> ch7_cfg_r.out_ctl == occr_out_t'($past(ch7_ctrl_w[`OCCR_OUT_MSB:`OCCR_OUT_LSB]));
   endproperty
   a_out_ctl: assert property (p_out_ctl) else $error("output control decode wrong");

   property p_driver;
      @(posedge sys_clk) disable iff (!arst_n)
      past_ok_r && !$past(ch6_ctrl_w[`OCCR_DRV_MSB]) |-> ch6_cfg_r.driver == OCCR_DRV_DIFF_LV;
   endproperty
   a_driver: assert property (p_driver) else $error("low driver codes not differential");

   property p_neg_gate;
      @(posedge sys_clk) disable iff (!arst_n)
      past_ok_r && $past(ch6_ctrl_w[`OCCR_NEG_BIT]) |->
         ch6_cfg_r.neg_on == $past(ch6_ctrl_w[`OCCR_POS_BIT]) && ch6_cfg_r.pos_on == ch6_cfg_r.neg_on;
   endproperty
   a_neg_gate: assert property (p_neg_gate) else $error("negative side not gated by positive side");

   property p_ch7_int;
      @(posedge sys_clk) disable iff (!arst_n)
      past_ok_r |-> ch7_cfg_r.int_ratio ==
         {1'b0, $past(ch7_div_w[`OCCR_INT_MSB:`OCCR_INT_LSB])} + 9'h001;
   endproperty
   a_ch7_int: assert property (p_ch7_int) else $error("channel seven integer ratio wrong");

   property p_unmapped;
      @(posedge sys_clk) disable iff (!arst_n)
      (req.rd_en && !mapped) |=> rd_valid_r && addr_err_r && rd_data_r == `OCCR_RST_WORD;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not answered with zero");

   property p_pos_on;
      @(posedge sys_clk) disable iff (!arst_n)
      past_ok_r |-> ch7_cfg_r.pos_on == $past(ch7_ctrl_w[`OCCR_POS_BIT]);
   endproperty
   a_pos_on: assert property (p_pos_on) else $error("positive single-ended enable wrong");

   property p_slow_edge;
      @(posedge sys_clk) disable iff (!arst_n)
      past_ok_r |-> ch6_cfg_r.slow_edge == $past(ch6_ctrl_w[`OCCR_SLOW_BIT]);
   endproperty
   a_slow_edge: assert property (p_slow_edge) else $error("slow edge select wrong");

   property p_supply;
      @(posedge sys_clk) disable iff (!arst_n)
      past_ok_r |-> ch7_cfg_r.supply_high == $past(ch7_ctrl_w[`OCCR_SUPPLY_BIT]);
   endproperty
   a_supply: assert property (p_supply) else $error("supply range select wrong");

   // channel seven must follow its own enable, not channel six's
   property p_ch7_bypass;
      @(posedge sys_clk) disable iff (!arst_n)
      past_ok_r |-> ch7_cfg_r.prescale_bypass == !$past(ch7_ctrl_w[`OCCR_FRAC_ON_BIT]);
   endproperty
   a_ch7_bypass: assert property (p_ch7_bypass) else $error("channel seven bypass not from its own word");

   property p_ch6_low;
      @(posedge sys_clk) disable iff (!arst_n)
      (req.wr_en && req.addr == `OCCR_OFS_CH6_FRAC_LO)
      |=> chan_six_fraction_low_r == $past(req.wdata);
   endproperty
   a_ch6_low: assert property (p_ch6_low) else $error("channel six fraction low not stored");

   property p_rsvd_div;
      @(posedge sys_clk) disable iff (!arst_n)
      (req.wr_en && req.addr == `OCCR_OFS_CH6_DIV)
      |=> rsvd_wr_r == $past(|(req.wdata & `OCCR_RSVD_DIV));
   endproperty
   a_rsvd_div: assert property (p_rsvd_div) else $error("reserved divider bits not flagged");

   property p_rd_ok;
      @(posedge sys_clk) disable iff (!arst_n)
      (req.rd_en && mapped) |=> rd_valid_r && !addr_err_r;
   endproperty
   a_rd_ok: assert property (p_rd_ok) else $error("mapped read not answered cleanly");

   property p_unmapped_wr;
      @(posedge sys_clk) disable iff (!arst_n)
      (req.wr_en && !mapped) |=> addr_err_r && !rsvd_wr_r
         && $stable(chan_five_fraction_low_r) && $stable(chan_six_fraction_low_r);
   endproperty
   a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write changed a word");

   // straight after reset the supply bits read low and may be set later
   property p_reset_vals;
      @(posedge sys_clk) disable iff (!arst_n)
      !past_ok_r |-> !ch6_cfg_r.supply_high && !ch7_cfg_r.supply_high
         && chan_five_fraction_low_r == `OCCR_RST_WORD;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("words not cleared after reset");

   property p_c_ctrl_write;
      @(posedge sys_clk) disable iff (!arst_n)
      req.wr_en && req.addr == `OCCR_OFS_CH6_CTRL ##1 req.rd_en;
   endproperty
   c_ctrl_write: cover property (p_c_ctrl_write);

   property p_c_neg_on;
      @(posedge sys_clk) disable iff (!arst_n)
      ch7_cfg_r.neg_on && ch7_cfg_r.driver == OCCR_DRV_SINGLE;
   endproperty
   c_neg_on: cover property (p_c_neg_on);

   property p_c_unmapped;
      @(posedge sys_clk) disable iff (!arst_n)
      addr_err_r && rd_valid_r;
   endproperty
   c_unmapped: cover property (p_c_unmapped);

   property p_c_div3;
      @(posedge sys_clk) disable iff (!arst_n)
      ch6_cfg_r.frac_on && ch6_cfg_r.prescale_ratio == 2'h3;
   endproperty
   c_div3: cover property (p_c_div3);

endmodule : occr_top

`default_nettype wire

// *** test/occr_tb.sv ***
// self-checking bench for the output channel configuration bank.
// assumes occr_pkg and rtl compile first and occr_regs.svh is on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "occr_regs.svh"

module tb;
   import occr_pkg::*;

   logic                 sys_clk;
   logic                 arst_n;
   occr_req_t            req;
   wire [15:0]           rd_data_r;
   wire                  rd_valid_r;
   wire                  addr_err_r;
   wire                  rsvd_wr_r;
   wire [15:0]           ch5_lo;
   wire [15:0]           ch6_lo;
   wire occr_chan_cfg_t  ch6_cfg_r;
   wire occr_chan_cfg_t  ch7_cfg_r;
   int                   n_fail;
   int                   checks_done;
   logic [15:0]          got;
   logic                 err;
   logic                 rsv;

   occr_top occr_top_i (
      .sys_clk                  (sys_clk),
      .arst_n                   (arst_n),
      .req                      (req),
      .rd_data_r                (rd_data_r),
      .rd_valid_r               (rd_valid_r),
      .addr_err_r               (addr_err_r),
      .rsvd_wr_r                (rsvd_wr_r),
      .chan_five_fraction_low_r (ch5_lo),
      .ch6_cfg_r                (ch6_cfg_r),
      .chan_six_fraction_low_r  (ch6_lo),
      .ch7_cfg_r                (ch7_cfg_r)
   );

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wrap_up;
      $display("Counts: %0d checks, %0d mismatches", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up

   // one request, then an idle cycle; flags sampled after the taking edge settles
   task automatic access(input logic w, input logic r, input logic [5:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      req <= {w, r, a, d};
      @(posedge sys_clk);
      req <= '0;
      #1;
      got = rd_data_r;
      err = addr_err_r;
      rsv = rsvd_wr_r;
      check("rd_valid", rd_valid_r, r);
   endtask : access

   // expected decode, worked out bit by bit from the field layout
   function automatic occr_chan_cfg_t exp_cfg(input logic [15:0] c, input logic [15:0] d);
      occr_chan_cfg_t e;
      e = '0;
      e.int_ratio = {1'b0, d[11:4]} + 9'h001;
      e.frac_hi = d[3:0];
      e.frac_on = c[9];
      e.prescale_bypass = !c[9];
      e.prescale_ratio = 2'h1;
      if (c[9] && c[12:10] == 3'h0) begin
         e.prescale_ratio = 2'h2;
      end
      if (c[9] && c[12:10] == 3'h1) begin
         e.prescale_ratio = 2'h3;
      end
      e.prescale_bad = c[9] && !(c[12:10] inside {3'h0, 3'h1, 3'h7});
      e.driver = c[4] ? (c[3] ? OCCR_DRV_HOST_DIFF : OCCR_DRV_SINGLE) : OCCR_DRV_DIFF_LV;
      e.pos_on = c[6];
      e.neg_on = c[7] & c[6];
      e.slow_edge = c[8];
      e.out_ctl = occr_out_t'(c[2:1]);
      e.supply_high = c[0];
      return e;
   endfunction : exp_cfg

   // every word reads zero and both channels show the zero-word decode
   task automatic t_rst_vals;
      check("rst_ch6_cfg", ch6_cfg_r, exp_cfg(16'h0000, 16'h0000));
      check("rst_ch7_cfg", ch7_cfg_r, exp_cfg(16'h0000, 16'h0000));
      for (int a = 14; a <= 19; a++) begin
         access(1'b0, 1'b1, 6'(a), 16'h0000);
         check("rst_word", {err, got}, 17'h00000);
      end
   endtask : t_rst_vals

   task automatic t_ctrl(input logic [5:0] ca, input logic [5:0] da, input logic [15:0] dv, input logic sel7);
      logic [15:0] words [5] = '{16'h02D3, 16'h071C, 16'h1E8E, 16'h0A40, 16'h0401};
      access(1'b1, 1'b0, da, dv);
      for (int i = 0; i < 5; i++) begin
         access(1'b1, 1'b0, ca, words[i]);
         check("ctrl_no_rsvd", rsv, 1'b0);
         access(1'b0, 1'b1, ca, 16'h0000);
         check("ctrl_readback", got, words[i]);
         if (sel7) begin
            check("ch7_cfg", ch7_cfg_r, exp_cfg(words[i], dv));
         end else begin
            check("ch6_cfg", ch6_cfg_r, exp_cfg(words[i], dv));
         end
      end
   endtask : t_ctrl

   // fraction words, then a write and a read of one word taken at the same edge
   task automatic t_frac_words;
      access(1'b1, 1'b0, `OCCR_OFS_CH6_FRAC_LO, 16'hBEEF);
      check("ch6_frac_low", ch6_lo, 16'hBEEF);
      @(posedge sys_clk);
      req <= {1'b1, 1'b0, `OCCR_OFS_CH5_FRAC_LO, 16'h1234};
      @(posedge sys_clk);
      req <= {1'b1, 1'b1, `OCCR_OFS_CH5_FRAC_LO, 16'h5678};
      @(posedge sys_clk);
      req <= '0;
      #1;
      check("same_cycle_rd", rd_data_r, 16'h1234);
      check("ch5_frac_low", ch5_lo, 16'h5678);
      access(1'b0, 1'b1, `OCCR_OFS_CH5_FRAC_LO, 16'h0000);
      check("ch5_readback", got, 16'h5678);
      // write then read back on the very next edge
      @(posedge sys_clk);
      req <= {1'b1, 1'b0, `OCCR_OFS_CH6_FRAC_LO, 16'hC0DE};
      @(posedge sys_clk);
      req <= {1'b0, 1'b1, `OCCR_OFS_CH6_FRAC_LO, 16'h0000};
      @(posedge sys_clk);
      req <= '0;
      #1;
      check("b2b_readback", rd_data_r, 16'hC0DE);
      check("b2b_valid", rd_valid_r, 1'b1);
   endtask : t_frac_words

   // reserved bits set, and the addresses just outside the bank
   task automatic t_refuse;
      access(1'b1, 1'b0, `OCCR_OFS_CH6_CTRL, 16'h8000);
      check("rsvd_ctrl", rsv, 1'b1);
      access(1'b0, 1'b1, `OCCR_OFS_CH6_CTRL, 16'h0000);
      check("rsvd_readback", got, 16'h8000);
      access(1'b1, 1'b0, `OCCR_OFS_CH7_CTRL, 16'h0020);
      check("rsvd_ctrl7", rsv, 1'b1);
      access(1'b1, 1'b0, `OCCR_OFS_CH6_DIV, 16'h1000);
      check("rsvd_div", rsv, 1'b1);
      access(1'b1, 1'b0, `OCCR_OFS_CH5_FRAC_LO, 16'hFFFF);
      check("frac_no_rsvd", rsv, 1'b0);
      access(1'b1, 1'b0, 6'h14, 16'hFFFF);
      check("unmapped_wr", {err, rsv}, 2'b10);
      access(1'b0, 1'b1, 6'h0D, 16'h0000);
      check("unmapped_rd", {err, got}, 17'h10000);
      access(1'b0, 1'b1, `OCCR_OFS_CH7_DIV, 16'h0000);
      check("ch7_div_kept", {err, got}, 17'h00013);
   endtask : t_refuse

   initial begin
      req = '0;
      arst_n = 1'b0;
      n_fail = 0;
      checks_done = 0;
      repeat (6) @(posedge sys_clk);
      arst_n <= 1'b1;
      #1;
      t_rst_vals();
      t_ctrl(`OCCR_OFS_CH6_CTRL, `OCCR_OFS_CH6_DIV, 16'h0FFA, 1'b0);
      t_ctrl(`OCCR_OFS_CH7_CTRL, `OCCR_OFS_CH7_DIV, 16'h0013, 1'b1);
      t_frac_words();
      t_refuse();
      // a second reset in mid-run must bring back the zero words
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      #1;
      t_rst_vals();
      wrap_up();
   end

   // the sequence needs well under 400 cycles
   initial begin
      #(20 * 3000);
      n_fail++;
      wrap_up();
   end

endmodule : tb

`default_nettype wire
